// ===== dv/dmx_core_asserts.sv
// Port assertions for the multichannel transfer engine
`timescale 1ns/1ps
`include "dmx_cfg.svh"
module dmx_core_asserts (
	// Watched ports
	input wire logic core_clk,
	input wire logic rst_n,
	input wire logic hlda,
	input wire logic hreq,
	input wire logic [`DMX_NCH-1:0] dack,
	input wire logic aen,
	input wire logic [31:0] addrOut,
	input wire logic dataOe,
	input wire dmx_pkg::dmx_strobe_t strobes
);
	import dmx_pkg::*;
	// Strobes seen just after the rising edge; a change there breaks the falling-edge timing
	logic [4:0] strbPos_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			strbPos_q <= 5'h1F;
		end else begin
			strbPos_q <= strobes;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_idle_quiet: assert property (!hreq |-> !aen && dack == '0 && !dataOe)
		else $error("outputs active while idle");
	a_addr_idle: assert property (!aen |-> addrOut == 32'h0)
		else $error("address driven outside transfer");
	a_copy_noack: assert property (dataOe |-> aen && dack == '0)
		else $error("acknowledge during copy");
	a_grant_first: assert property ($rose(aen) |-> hreq && $past(hlda, 2))
		else $error("transfer without grant");
	a_ack_onehot: assert property ($onehot0(dack))
		else $error("several acknowledges");
	a_strobe_fall: assert property (@(negedge core_clk) strobes == strbPos_q)
		else $error("strobe moved on rising edge");
	a_temp_write: assert property ($rose(dataOe) |-> !strobes.memWrN)
		else $error("holding data without write strobe");
	a_hold_end: assert property ($fell(hreq) |-> !aen && !dataOe)
		else $error("bus request dropped mid transfer");
	a_eop_span: assert property (!strobes.eopOutN |-> $past(aen))
		else $error("end output outside transfer");
endmodule : dmx_core_asserts
bind dmx_core dmx_core_asserts dmx_core_asserts_inst (.core_clk, .rst_n, .hlda, .hreq, .dack,
	.aen, .addrOut, .dataOe, .strobes);

// ===== dv/dmx_host_model.sv
// Host processor granting the bus, with memory read data and wait states
`timescale 1ns/1ps
module dmx_host_model #(
	parameter logic [63:0] DATA = 64'h0123456789ABCDEF
) (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// Bus hold and memory side
	input wire logic hreq,
	input wire logic slow,
	output logic hlda,
	output logic ready,
	output logic [63:0] dataIn
);
	logic [2:0] waitCnt_q;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			waitCnt_q <= 3'h0;
			hlda <= 1'b0;
			ready <= 1'b0;
		end else begin
			waitCnt_q <= hreq ? waitCnt_q + 3'h1 : 3'h0;
			hlda <= hreq && (hlda || waitCnt_q == (slow ? 3'h5 : 3'h1));
			ready <= slow && !ready;
		end
	end
	// Data only meaningful while granted
	assign dataIn = hlda ? DATA : ~DATA;
endmodule : dmx_host_model

// ===== dv/tb_top.sv
// Register and transfer tests for the multichannel transfer engine
`timescale 1ns/1ps
module tb_top;
	import dmx_pkg::*;
	localparam logic [63:0] MEMWORD = 64'h0123456789ABCDEF;
	logic core_clk = 1'b0, rst_n = 1'b0, slow = 1'b0, eopIn_n = 1'b1;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [15:0] dreq = 16'h0000, dack;
	logic hlda, ready, hreq, aen, dataOe;
	logic [31:0] addrOut, wrAddr;
	logic [63:0] dataIn, dataOut, wrWord;
	dmx_strobe_t strobes;
	int errCount = 0, nCompared = 0, cycles = 0, nIo = 0, nMw = 0, nEop = 0;
	dmx_core dmx_core_inst (.*);
	dmx_host_model #(.DATA(MEMWORD)) dmx_host_model_inst (.core_clk, .rst_n, .hreq, .slow,
		.hlda, .ready, .dataIn);
	initial begin
		forever #20 core_clk = ~core_clk;
	end
	always @(negedge strobes.ioRdN) nIo++;
	always @(negedge strobes.memWrN) nMw++;
	always @(negedge strobes.eopOutN) nEop++;
	// Word and address seen on the bus while the holding register is driven
	always @(negedge core_clk) begin
		if (dataOe) begin
			wrWord = dataOut;
			wrAddr = addrOut;
		end
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		nCompared++;
		if (got !== exp) begin
			errCount++;
			$display("Error %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		logic pa, pw;
		pa = 1'b1;
		pw = 1'b1;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		while (pa || pw) begin
			@(negedge core_clk);
			pa = pa && !s_axi_awready;
			pw = pw && !s_axi_wready;
			@(posedge core_clk);
			s_axi_awvalid <= pa;
			s_axi_wvalid <= pw;
		end
		s_axi_bready <= 1'b1;
		do @(negedge core_clk); while (!s_axi_bvalid);
		@(posedge core_clk);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rc(input logic [11:0] a, input logic [31:0] e, input logic [1:0] er);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do @(negedge core_clk); while (!s_axi_arready);
		@(posedge core_clk);
		s_axi_arvalid <= 1'b0;
		s_axi_rready <= 1'b1;
		do @(negedge core_clk); while (!s_axi_rvalid);
		chk(s_axi_rdata, e);
		chk(s_axi_rresp, er);
		@(posedge core_clk);
		s_axi_rready <= 1'b0;
	endtask : rc
	task automatic conclude();
		if (errCount == 0 && nCompared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : conclude
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errCount++;
			conclude();
		end
	end
	initial begin
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge core_clk);
		rc(12'h000, 32'h00000F00, 2'h0);
		rc(12'h0FC, 32'h0, 2'h2);
		wr(12'h004, 32'hFFFFFFFF, 4'h2);
		rc(12'h004, 32'h0000FF00, 2'h0);
		wr(12'h004, 32'h0, 4'hF);
		wr(12'h000, 32'h00000FB0, 4'hF);
		rc(12'h000, 32'h00000FB0, 2'h0);
		// Block I/O to memory on channel 2, two words
		wr(12'h120, 32'h00001000, 4'hF);
		wr(12'h128, 32'h1, 4'hF);
		wr(12'h12C, 32'h24, 4'hF);
		dreq[2] <= 1'b1;
		do @(negedge core_clk); while (!dack[2]);
		@(posedge core_clk);
		dreq[2] <= 1'b0;
		do @(negedge core_clk); while (hreq);
		@(posedge core_clk);
		chk(nIo, 2);
		rc(12'h120, 32'h00001002, 2'h0);
		rc(12'h010, 32'h00000004, 2'h0);
		// Memory copy on channel 0 with wait states, cut to one word by the end input
		slow <= 1'b1;
		wr(12'h100, 32'h00002000, 4'hF);
		wr(12'h104, 32'h00003000, 4'hF);
		wr(12'h108, 32'h5, 4'hF);
		wr(12'h10C, 32'h21, 4'hF);
		dreq[0] <= 1'b1;
		do @(negedge core_clk); while (!aen);
		@(posedge core_clk);
		dreq[0] <= 1'b0;
		eopIn_n <= 1'b0;
		do @(negedge core_clk); while (hreq);
		@(posedge core_clk);
		eopIn_n <= 1'b1;
		chk(nMw, 3);
		chk(nEop, 2);
		chk(wrWord, MEMWORD);
		chk(wrAddr, 32'h00003000);
		rc(12'h014, MEMWORD[31:0], 2'h0);
		// Cascade request must never start
		slow <= 1'b0;
		wr(12'h13C, 32'h30, 4'hF);
		dreq[3] <= 1'b1;
		repeat (20) @(posedge core_clk);
		chk(hreq, 32'h0);
		conclude();
	end
endmodule : tb_top

// ===== verilog/dmx_axi_slave.sv
// AXI4-Lite slave front end that turns bus transfers into register accesses
`timescale 1ns/1ps
`include "dmx_cfg.svh"
module dmx_axi_slave (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// AXI4-Lite
	input wire logic [`DMX_RA_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`DMX_RA_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Register file side
	output dmx_pkg::dmx_regreq_t regReq,
	input wire logic wrHit,
	input wire logic rdHit,
	input wire logic [31:0] rdData
);
	import dmx_pkg::*;
	logic awHeld_q, wHeld_q, arHeld_q;
	logic [`DMX_RA_W-1:0] awAddr_q, arAddr_q;
	logic [31:0] wData_q;
	logic [3:0] wStrb_q;
	logic wrFire;
	assign wrFire = awHeld_q && wHeld_q && !s_axi_bvalid;
	assign regReq = '{wr: wrFire, waddr: awAddr_q, wdata: wData_q, wstrb: wStrb_q,
		raddr: arAddr_q};
	// ****************
	// Write channels, taken in either order
	// ****************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			awHeld_q <= 1'b0;
			wHeld_q <= 1'b0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `DMX_RESP_OKAY;
			awAddr_q <= '0;
			wData_q <= '0;
			wStrb_q <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awHeld_q <= 1'b1;
				awAddr_q <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end else if (!awHeld_q) begin
				s_axi_awready <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wHeld_q <= 1'b1;
				wData_q <= s_axi_wdata;
				wStrb_q <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end else if (!wHeld_q) begin
				s_axi_wready <= 1'b1;
			end
			if (wrFire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wrHit ? `DMX_RESP_OKAY : `DMX_RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				awHeld_q <= 1'b0;
				wHeld_q <= 1'b0;
			end
		end
	end
	// ****************
	// Read channels
	// ****************
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			arHeld_q <= 1'b0;
			arAddr_q <= '0;
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= `DMX_RESP_OKAY;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				arHeld_q <= 1'b1;
				arAddr_q <= s_axi_araddr;
				s_axi_arready <= 1'b0;
			end else if (arHeld_q && !s_axi_rvalid) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rdHit ? rdData : 32'h00000000;
				s_axi_rresp <= rdHit ? `DMX_RESP_OKAY : `DMX_RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				arHeld_q <= 1'b0;
			end else if (!arHeld_q) begin
				s_axi_arready <= 1'b1;
			end
		end
	end
endmodule : dmx_axi_slave

// ===== verilog/dmx_cfg.svh
// Constants for the multichannel transfer engine: map, fields, codes and reset values
`ifndef DMX_CFG_SVH
`define DMX_CFG_SVH
`define DMX_NCH 16
`define DMX_LEGACY_NCH 5'h04
`define DMX_RA_W 12
// ****************
// Register map
// ****************
`define DMX_A_CTRL 12'h000
`define DMX_A_MASK 12'h004
`define DMX_A_SWREQ 12'h008
`define DMX_A_STATUS 12'h00C
`define DMX_A_TC 12'h010
`define DMX_A_TEMPLO 12'h014
`define DMX_A_TEMPHI 12'h018
`define DMX_CH_PAGE 4'h1
`define DMX_F_CUR 2'h0
`define DMX_F_DST 2'h1
`define DMX_F_CNT 2'h2
`define DMX_F_MODE 2'h3
// ****************
// Control fields
// ****************
`define DMX_C_LEGACY 0
`define DMX_C_MEMEN 1
`define DMX_C_COMPR 2
`define DMX_C_SWRST 3
`define DMX_C_DW 5:4
`define DMX_C_AW 7:6
`define DMX_C_NCH 11:8
`define DMX_C_DRQLOW 12
`define DMX_CTRL_RST 32'h00000F00
// ****************
// Mode fields and codes
// ****************
`define DMX_M_M2M 0
`define DMX_M_DEC 1
`define DMX_M_TYPE 3:2
`define DMX_M_XMODE 5:4
`define DMX_X_DEMAND 2'h0
`define DMX_X_SINGLE 2'h1
`define DMX_X_CASCADE 2'h3
`define DMX_T_WRITE 2'h1
`define DMX_T_READ 2'h2
`define DMX_W_8 2'h0
`define DMX_W_16 2'h1
`define DMX_W_32 2'h2
`define DMX_RESP_OKAY 2'h0
`define DMX_RESP_SLVERR 2'h2
`endif

// ===== verilog/dmx_core.sv
// Multichannel transfer engine: register file, request selection and transfer state machine
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "dmx_cfg.svh"
// How it works
// - Legacy mode has four fixed channels; extended mode enables one to sixteen.
// - Extended mode selects data and address widths; legacy forces 8 and 16 bits.
// - A pending request set to cascade sends the machine back to idle.
// - Upper address byte is held internally; no external latch strobe exists.
// - Register writes from the bus slave happen on the core clock.
// - Writes decode address and honour byte enables, except software request and terminal count; reads steer the chosen register.
// - Data output carries the holding register in the third and fourth write states; register reads go to the bus slave.
// - A valid request in idle raises bus-hold request and enters bus acquire.
// - In acquire, if the request drops and nothing pends, go idle; else hold.
// - Grant leads to memory-copy or I/O states; registers programmable until grant.
// - A memory copy runs four read and four write states, repeated until the last transfer.
// - I/O transfers loop through three states; legacy compressed timing skips the middle one.
// - Transfers end on count overflow, end input, grant drop, or demand request drop.
// - End-of-process output asserts on the falling edge of the last state.
// - All memory and I/O strobes change on the falling clock edge.
// - Legacy memory copy needs the enable bit, channel 0 request and priority.
// - Extended memory copy is flagged by mode bit zero of the serviced channel.
// - Hardware reset, and legacy software reset, put the machine idle, outputs inactive.
// - First copy state: no acknowledge, address enable on, source address, strobes off.
// - End input during any copy state stops service after the current cycle.
// - Second copy state asserts memory read, keeps address, then moves on.
// - Third read state waits while ready is high and leaves when it drops.
// - Fourth read state drops memory read and loads the holding register.
// - First write state drives the destination address with both memory strobes off.
// - Third write state asserts memory write, drives the holding register, waits on ready.
module dmx_core (
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst_n,
	// AXI4-Lite register port
	input wire logic [`DMX_RA_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [`DMX_RA_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Requests and bus hold handshake
	input wire logic [`DMX_NCH-1:0] dreq,
	input wire logic hlda,
	input wire logic eopIn_n,
	input wire logic ready,
	output logic hreq,
	output logic [`DMX_NCH-1:0] dack,
	// System bus
	output logic aen,
	output logic [31:0] addrOut,
	input wire logic [63:0] dataIn,
	output logic [63:0] dataOut,
	output logic dataOe,
	output dmx_pkg::dmx_strobe_t strobes
);
	import dmx_pkg::*;
	localparam int NCH = `DMX_NCH;
	localparam int SW = NCH + 3 + 64;

	// ****************
	// Input synchronisers
	// ****************
	logic [SW-1:0] pinMeta_q, pinSync_q;
	logic [NCH-1:0] dreqS;
	logic hldaS, eopInS_n, readyS;
	logic [63:0] dataInS;
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pinMeta_q <= '0;
			pinSync_q <= '0;
		end else begin
			pinMeta_q <= {dreq, hlda, eopIn_n, ready, dataIn};
			pinSync_q <= pinMeta_q;
		end
	end
	assign {dreqS, hldaS, eopInS_n, readyS, dataInS} = pinSync_q;

	// ****************
	// Helpers
	// ****************
	function automatic logic [4:0] pickChan(input logic [NCH-1:0] v);
		logic [4:0] r;
		r = 5'h00;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (v[i]) begin
				r = {1'b1, 4'(i)};
			end
		end
		return r;
	endfunction : pickChan

	function automatic logic [31:0] laneMerge(input logic [31:0] old, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction : laneMerge

	function automatic logic [31:0] stepAddr(input logic [31:0] a, input logic dec);
		return dec ? a - 32'h00000001 : a + 32'h00000001;
	endfunction : stepAddr

	// ****************
	// Register storage and decode
	// ****************
	dmx_regreq_t regReq;
	logic wrHit, rdHit;
	logic [31:0] rdData;
	logic [31:0] ctrl_q;
	logic [NCH-1:0] mask_q, swReq_q, tc_q;
	logic [63:0] temp_q;
	logic [31:0] curAddr_q [NCH];
	logic [31:0] dstAddr_q [NCH];
	logic [31:0] wordCnt_q [NCH];
	logic [7:0] mode_q [NCH];
	dmx_state_t state_q, state_d;
	logic [3:0] chan_q, chan_d;
	logic stopReq_q;
	logic wrCtrl, wrMask, wrSwReq, wrTc;
	logic [NCH-1:0] wrChan;
	logic [3:0] wChIdx, rChIdx;
	logic [1:0] wField, rField;
	logic progOk, legacy, swReset;

	assign wChIdx = regReq.waddr[7:4];
	assign wField = regReq.waddr[3:2];
	assign rChIdx = regReq.raddr[7:4];
	assign rField = regReq.raddr[3:2];
	// Configuration is frozen once the bus has been granted
	assign progOk = (state_q == ST_SI) || (state_q == ST_S0);
	assign legacy = ctrl_q[`DMX_C_LEGACY];

	always_comb begin
		wrCtrl = 1'b0;
		wrMask = 1'b0;
		wrSwReq = 1'b0;
		wrTc = 1'b0;
		wrChan = '0;
		wrHit = 1'b1;
		if (regReq.waddr == `DMX_A_CTRL) begin
			wrCtrl = regReq.wr;
		end else if (regReq.waddr == `DMX_A_MASK) begin
			wrMask = regReq.wr;
		end else if (regReq.waddr == `DMX_A_SWREQ) begin
			wrSwReq = regReq.wr;
		end else if (regReq.waddr == `DMX_A_TC) begin
			wrTc = regReq.wr;
		end else if (regReq.waddr[11:8] == `DMX_CH_PAGE) begin
			wrChan[wChIdx] = regReq.wr;
		end else if (regReq.waddr == `DMX_A_STATUS || regReq.waddr == `DMX_A_TEMPLO ||
			regReq.waddr == `DMX_A_TEMPHI) begin
			wrHit = 1'b1;
		end else begin
			wrHit = 1'b0;
		end
	end

	always_comb begin
		rdHit = 1'b1;
		rdData = 32'h00000000;
		if (regReq.raddr == `DMX_A_CTRL) begin
			rdData = ctrl_q;
		end else if (regReq.raddr == `DMX_A_MASK) begin
			rdData = 32'(mask_q);
		end else if (regReq.raddr == `DMX_A_SWREQ) begin
			rdData = 32'(swReq_q);
		end else if (regReq.raddr == `DMX_A_STATUS) begin
			rdData = {24'h000000, chan_q, state_q};
		end else if (regReq.raddr == `DMX_A_TC) begin
			rdData = 32'(tc_q);
		end else if (regReq.raddr == `DMX_A_TEMPLO) begin
			rdData = temp_q[31:0];
		end else if (regReq.raddr == `DMX_A_TEMPHI) begin
			rdData = temp_q[63:32];
		end else if (regReq.raddr[11:8] == `DMX_CH_PAGE) begin
			if (rField == `DMX_F_CUR) begin
				rdData = curAddr_q[rChIdx];
			end else if (rField == `DMX_F_DST) begin
				rdData = dstAddr_q[rChIdx];
			end else if (rField == `DMX_F_CNT) begin
				rdData = wordCnt_q[rChIdx];
			end else begin
				rdData = 32'(mode_q[rChIdx]);
			end
		end else begin
			rdHit = 1'b0;
		end
	end

	// Software reset exists only while legacy mode is selected
	assign swReset = wrCtrl && legacy && regReq.wdata[`DMX_C_SWRST];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_q <= `DMX_CTRL_RST;
			mask_q <= '0;
		end else if (progOk) begin
			if (wrCtrl) begin
				ctrl_q <= laneMerge(ctrl_q, regReq.wdata, regReq.wstrb);
			end
			if (wrMask) begin
				mask_q <= NCH'(laneMerge(32'(mask_q), regReq.wdata, regReq.wstrb));
			end
		end
	end

	// ****************
	// Request qualification
	// ****************
	logic [4:0] nChan;
	logic [NCH-1:0] reqLvl, chanOn, cascade, pendAll, validReq;
	logic [4:0] pickValid;
	logic m2mDet, xferDone, lastXfer, endCause, isM2m, isIo;
	logic [3:0] chanCont;
	logic [1:0] xMode, xType;

	assign nChan = legacy ? `DMX_LEGACY_NCH : {1'b0, ctrl_q[`DMX_C_NCH]} + 5'h01;
	assign reqLvl = (legacy && ctrl_q[`DMX_C_DRQLOW]) ? ~dreqS : dreqS;
	generate
		for (genvar g = 0; g < NCH; g++) begin : gQual
			assign chanOn[g] = 5'(g) < nChan;
			assign cascade[g] = mode_q[g][`DMX_M_XMODE] == `DMX_X_CASCADE;
		end
	endgenerate
	assign pendAll = (reqLvl | swReq_q) & ~mask_q & chanOn;
	assign validReq = pendAll & ~cascade;
	assign pickValid = pickChan(validReq);
	assign chanCont = pendAll[chan_q] ? chan_q : pickValid[3:0];
	assign m2mDet = legacy
		? (ctrl_q[`DMX_C_MEMEN] && reqLvl[0] && chanCont == 4'h0)
		: mode_q[chanCont][`DMX_M_M2M];
	assign xMode = mode_q[chan_q][`DMX_M_XMODE];
	assign xType = mode_q[chan_q][`DMX_M_TYPE];
	// End of block: count overflow or external end; other causes only pause service
	assign endCause = (wordCnt_q[chan_q] == 32'h00000000) || stopReq_q || !eopInS_n;
	assign lastXfer = endCause || !hldaS || (xMode == `DMX_X_SINGLE) ||
		((xMode == `DMX_X_DEMAND) && !reqLvl[chan_q] && !swReq_q[chan_q]);
	assign xferDone = (state_q == ST_S4 || state_q == ST_S24) && !readyS;
	assign isM2m = state_q inside {ST_S11, ST_S12, ST_S13, ST_S14, ST_S21, ST_S22, ST_S23,
		ST_S24};
	assign isIo = state_q inside {ST_S2, ST_S3, ST_S4};

	// ****************
	// Transfer state machine
	// ****************
	always_comb begin
		state_d = state_q;
		chan_d = chan_q;
		case (state_q)
			ST_SI: begin
				if (pickValid[4]) begin
					state_d = ST_S0;
					chan_d = pickValid[3:0];
				end
			end
			ST_S0: begin
				if (!pendAll[chan_q] && !pickValid[4]) begin
					state_d = ST_SI;
				end else if (cascade[chanCont]) begin
					state_d = ST_SI;
				end else begin
					chan_d = chanCont;
					if (hldaS) begin
						state_d = m2mDet ? ST_S11 : ST_S2;
					end
				end
			end
			ST_S11: state_d = ST_S12;
			ST_S12: state_d = ST_S13;
			ST_S13: state_d = readyS ? ST_S13 : ST_S14;
			ST_S14: state_d = ST_S21;
			ST_S21: state_d = ST_S22;
			ST_S22: state_d = ST_S23;
			ST_S23: state_d = readyS ? ST_S23 : ST_S24;
			ST_S24: begin
				if (!readyS) begin
					state_d = lastXfer ? ST_SI : ST_S11;
				end
			end
			ST_S2: begin
				state_d = (legacy && ctrl_q[`DMX_C_COMPR]) ? ST_S4 : ST_S3;
			end
			ST_S3: state_d = ST_S4;
			ST_S4: begin
				if (!readyS) begin
					state_d = lastXfer ? ST_SI : ST_S2;
				end
			end
			default: state_d = ST_SI;
		endcase
		if (swReset) begin
			state_d = ST_SI;
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_SI;
			chan_q <= 4'h0;
		end else begin
			state_q <= state_d;
			chan_q <= chan_d;
		end
	end

	// An end request seen in any copy state is kept until the current cycle ends
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			stopReq_q <= 1'b0;
		end else if (state_q == ST_SI) begin
			stopReq_q <= 1'b0;
		end else if (isM2m && !eopInS_n) begin
			stopReq_q <= 1'b1;
		end
	end

	// ****************
	// Channel registers and counters
	// ****************
	generate
		for (genvar c = 0; c < NCH; c++) begin : gChan
			always_ff @(posedge core_clk or negedge rst_n) begin
				if (!rst_n) begin
					curAddr_q[c] <= 32'h00000000;
					dstAddr_q[c] <= 32'h00000000;
					wordCnt_q[c] <= 32'h00000000;
					mode_q[c] <= 8'h00;
				end else if (wrChan[c] && progOk) begin
					if (wField == `DMX_F_CUR) begin
						curAddr_q[c] <= laneMerge(curAddr_q[c], regReq.wdata, regReq.wstrb);
					end else if (wField == `DMX_F_DST) begin
						dstAddr_q[c] <= laneMerge(dstAddr_q[c], regReq.wdata, regReq.wstrb);
					end else if (wField == `DMX_F_CNT) begin
						wordCnt_q[c] <= laneMerge(wordCnt_q[c], regReq.wdata, regReq.wstrb);
					end else begin
						mode_q[c] <= 8'(laneMerge(32'(mode_q[c]), regReq.wdata, regReq.wstrb));
					end
				end else if (xferDone) begin
					if (chan_q == 4'(c)) begin
						curAddr_q[c] <= stepAddr(curAddr_q[c], mode_q[c][`DMX_M_DEC]);
						wordCnt_q[c] <= wordCnt_q[c] - 32'h00000001;
						if (state_q == ST_S24 && !legacy) begin
							dstAddr_q[c] <= stepAddr(dstAddr_q[c], mode_q[c][`DMX_M_DEC]);
						end
					end
					// Legacy copies write through channel 1's current address
					if (c == 1 && state_q == ST_S24 && legacy) begin
						curAddr_q[c] <= stepAddr(curAddr_q[c], mode_q[c][`DMX_M_DEC]);
					end
				end
			end
		end
	endgenerate

	// Hardware set wins over a same-cycle write-one clear
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			tc_q <= '0;
			swReq_q <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (xferDone && chan_q == 4'(i) && wordCnt_q[i] == 32'h00000000) begin
					tc_q[i] <= 1'b1;
				end else if (wrTc && regReq.wdata[i]) begin
					tc_q[i] <= 1'b0;
				end
				if (wrSwReq && progOk) begin
					swReq_q[i] <= regReq.wdata[i];
				end else if (xferDone && lastXfer && chan_q == 4'(i)) begin
					swReq_q[i] <= 1'b0;
				end
			end
		end
	end

	// ****************
	// Holding register and bus outputs
	// ****************
	logic [63:0] dataMask;
	logic [31:0] addrMask, addrSel;
	logic [1:0] dw, aw;
	assign dw = legacy ? `DMX_W_8 : ctrl_q[`DMX_C_DW];
	assign aw = legacy ? `DMX_W_8 : ctrl_q[`DMX_C_AW];
	assign dataMask = (dw == `DMX_W_8) ? 64'h00000000000000FF :
		(dw == `DMX_W_16) ? 64'h000000000000FFFF :
		(dw == `DMX_W_32) ? 64'h00000000FFFFFFFF : 64'hFFFFFFFFFFFFFFFF;
	assign addrMask = (aw == `DMX_W_8) ? 32'h0000FFFF :
		(aw == `DMX_W_16) ? 32'h00FFFFFF : 32'hFFFFFFFF;

	always_comb begin
		if (state_d inside {ST_S11, ST_S12, ST_S13, ST_S14}) begin
			addrSel = legacy ? curAddr_q[0] : curAddr_q[chan_d];
		end else if (state_d inside {ST_S21, ST_S22, ST_S23, ST_S24}) begin
			addrSel = legacy ? curAddr_q[1] : dstAddr_q[chan_d];
		end else begin
			addrSel = curAddr_q[chan_d];
		end
	end

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			temp_q <= 64'h0000000000000000;
		end else if (state_q == ST_S14) begin
			temp_q <= dataInS & dataMask;
		end
	end

	// Outputs follow the next state so they line up with the state they belong to
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			hreq <= 1'b0;
			aen <= 1'b0;
			dack <= '0;
			addrOut <= 32'h00000000;
			dataOut <= 64'h0000000000000000;
			dataOe <= 1'b0;
		end else begin
			hreq <= state_d != ST_SI;
			aen <= !(state_d inside {ST_SI, ST_S0});
			dack <= (state_d inside {ST_S2, ST_S3, ST_S4}) ? NCH'(1) << chan_d : '0;
			// Full address held here; no separate strobe for the upper byte
			addrOut <= (state_d inside {ST_SI, ST_S0}) ? 32'h00000000 : addrSel & addrMask;
			dataOe <= state_d inside {ST_S23, ST_S24};
			dataOut <= (state_d inside {ST_S23, ST_S24}) ? temp_q : 64'h0000000000000000;
		end
	end

	// Strobes move on the falling edge, half a cycle after the state changes
	always_ff @(negedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			strobes <= '{memRdN: 1'b1, memWrN: 1'b1, ioRdN: 1'b1, ioWrN: 1'b1, eopOutN: 1'b1};
		end else begin
			strobes.memRdN <= !(state_q inside {ST_S12, ST_S13} ||
				(isIo && state_q != ST_S2 && xType == `DMX_T_READ));
			strobes.memWrN <= !(state_q == ST_S23 ||
				(isIo && state_q != ST_S2 && xType == `DMX_T_WRITE));
			strobes.ioRdN <= !(isIo && state_q != ST_S2 && xType == `DMX_T_WRITE);
			strobes.ioWrN <= !(isIo && state_q != ST_S2 && xType == `DMX_T_READ);
			strobes.eopOutN <= !((state_q == ST_S4 || state_q == ST_S24) && endCause);
		end
	end

	dmx_axi_slave uSlave (
		.core_clk(core_clk),
		.rst_n(rst_n),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.regReq(regReq),
		.wrHit(wrHit),
		.rdHit(rdHit),
		.rdData(rdData)
	);
endmodule : dmx_core

// ===== verilog/dmx_pkg.sv
// Shared types of the multichannel transfer engine
`include "dmx_cfg.svh"
package dmx_pkg;
	typedef enum logic [3:0] {
		ST_SI, ST_S0, ST_S11, ST_S12, ST_S13, ST_S14, ST_S21, ST_S22, ST_S23, ST_S24,
		ST_S2, ST_S3, ST_S4
	} dmx_state_t;
	// Active-low bus strobes, all changed on the falling clock edge
	typedef struct packed {
		logic memRdN;
		logic memWrN;
		logic ioRdN;
		logic ioWrN;
		logic eopOutN;
	} dmx_strobe_t;
	// Register access issued by the bus slave to the register file
	typedef struct packed {
		logic wr;
		logic [`DMX_RA_W-1:0] waddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic [`DMX_RA_W-1:0] raddr;
	} dmx_regreq_t;
endpackage : dmx_pkg
